//--- hbw_defs.svh
// Constants of the host bus width and word swap block.
`ifndef HBW_DEFS_SVH
`define HBW_DEFS_SVH
`define HBW_CFG_WIDTH_BIT 2
`define HBW_HALF_W 16
`define HBW_SWAP_ALL_ONES 32'hffffffff
`define HBW_CFG_RESET 32'h00000000
`define HBW_SWAP_NONE 32'h00000000
`define HBW_HI_MSB 31
`define HBW_HI_LSB 16
`define HBW_LO_MSB 15
`define HBW_OE_LOW_ONLY 32'h0000ffff
`define HBW_OE_ALL 32'hffffffff
`endif

//--- hbw_pkg.sv
// Types shared by the host bus width and word swap block.
package hbw_pkg;
	typedef struct packed {
		logic cs;
		logic wr;
		logic rd;
		logic a1;
		logic [29:0] dw_addr;
		logic [31:0] wdata;
	} hbw_host_req_t;
	typedef struct packed {
		logic wr;
		logic rd_adv;
		logic [29:0] dw_addr;
		logic [31:0] wdata;
	} hbw_int_req_t;
	typedef enum logic [2:0] {
		HBW_IDLE = 3'h1,
		HBW_HAVE_LO = 3'h2,
		HBW_HAVE_HI = 3'h4
	} hbw_pair_t;
	typedef struct packed {
		logic bus16;
		logic strap_taken;
		hbw_pair_t wpair;
		hbw_pair_t rpair;
		logic [15:0] whold;
		logic [31:0] rdata;
		logic [31:0] d_out;
		logic d_oe_lo;
		logic d_oe_hi;
		hbw_int_req_t ireq;
		logic [31:0] cfg;
		logic rd_drop;
		logic wr_drop;
	} hbw_state_t;
endpackage

//--- hbw_host_port.sv
// Host port width adapter: 16/32-bit pairing and word swap mapping.
`timescale 1ns/1ns
`include "hbw_defs.svh"
module hbw_host_port
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic serial_memory_data_strap_pin,
	input wire logic [31:0] word_swap,
	input wire hbw_pkg::hbw_host_req_t host_req,
	input wire logic [31:0] int_rdata,
	output logic [31:0] d_out,
	output logic [31:0] d_oe,
	output logic [31:0] hardware_configuration,
	output hbw_pkg::hbw_int_req_t int_req,
	output logic rd_pair_reset,
	output logic wr_discard
);
	hbw_pkg::hbw_state_t s_ff;
	hbw_pkg::hbw_state_t nxt_s;

	// Returns 1 when the half selected by a1 is the high internal word.
	function automatic logic hi_word(input logic a1, input logic [31:0] sw);
		if (sw == `HBW_SWAP_ALL_ONES)
			hi_word = ~a1;
		else
			hi_word = a1;
	endfunction

	// Picks the half of a doubleword that a 16-bit access moves.
	function automatic logic [15:0] pick_half(input logic hi,
		input logic [31:0] w);
		if (hi)
			pick_half = w[`HBW_HI_MSB:`HBW_HI_LSB];
		else
			pick_half = w[`HBW_LO_MSB:0];
	endfunction

	// True when an access hits the half that its pair already holds.
	function automatic logic same_half(input logic hi,
		input hbw_pkg::hbw_pair_t pair);
		same_half = hi == (pair == hbw_pkg::HBW_HAVE_HI);
	endfunction

	// Puts a half-word on the low lines; the upper lines read as zero.
	function automatic logic [31:0] low_lines(input logic [15:0] h);
		low_lines = {{`HBW_HALF_W{1'b0}}, h};
	endfunction

	logic hsel;
	logic [31:0] merged;

	always_comb
	begin
		nxt_s = s_ff;
		hsel = hi_word(host_req.a1, word_swap);
		merged = 32'h00000000;
		nxt_s.ireq.wr = 1'b0;
		nxt_s.ireq.rd_adv = 1'b0;
		nxt_s.rd_drop = 1'b0;
		nxt_s.wr_drop = 1'b0;
		nxt_s.d_oe_lo = 1'b0;
		nxt_s.d_oe_hi = 1'b0;
		// The strap is caught once on the first clock after reset release.
		if (!s_ff.strap_taken)
		begin
			nxt_s.strap_taken = 1'b1;
			nxt_s.bus16 = ~serial_memory_data_strap_pin;
			nxt_s.cfg = `HBW_CFG_RESET;
			nxt_s.cfg[`HBW_CFG_WIDTH_BIT] = serial_memory_data_strap_pin;
		end
		else if (host_req.cs && !s_ff.bus16)
		begin
			// Native width: a single access is the whole transfer.
			nxt_s.ireq.dw_addr = host_req.dw_addr;
			nxt_s.ireq.wdata = host_req.wdata;
			nxt_s.ireq.wr = host_req.wr;
			nxt_s.ireq.rd_adv = host_req.rd;
			if (host_req.rd)
			begin
				nxt_s.d_out = int_rdata;
				nxt_s.d_oe_lo = 1'b1;
				nxt_s.d_oe_hi = 1'b1;
			end
		end
		else if (host_req.cs && host_req.wr)
		begin
			unique case (s_ff.wpair)
				hbw_pkg::HBW_IDLE:
				begin
					nxt_s.whold = host_req.wdata[15:0];
					nxt_s.ireq.dw_addr = host_req.dw_addr;
					nxt_s.wpair = hsel ? hbw_pkg::HBW_HAVE_HI
						: hbw_pkg::HBW_HAVE_LO;
				end
				hbw_pkg::HBW_HAVE_LO, hbw_pkg::HBW_HAVE_HI:
				begin
					if (same_half(hsel, s_ff.wpair))
					begin
						// Same half twice: drop the whole doubleword.
						nxt_s.wr_drop = 1'b1;
						nxt_s.wpair = hbw_pkg::HBW_IDLE;
					end
					else
					begin
						if (hsel)
							merged = {host_req.wdata[15:0], s_ff.whold};
						else
							merged = {s_ff.whold, host_req.wdata[15:0]};
						nxt_s.ireq.wdata = merged;
						nxt_s.ireq.wr = 1'b1;
						nxt_s.wpair = hbw_pkg::HBW_IDLE;
					end
				end
				default:
					nxt_s.wpair = hbw_pkg::HBW_IDLE;
			endcase
		end
		else if (host_req.cs && host_req.rd)
		begin
			// Both halves come from one snapshot so the pair is coherent.
			unique case (s_ff.rpair)
				hbw_pkg::HBW_IDLE:
				begin
					nxt_s.rdata = int_rdata;
					nxt_s.d_out = low_lines(pick_half(hsel, int_rdata));
					nxt_s.ireq.dw_addr = host_req.dw_addr;
					nxt_s.rpair = hsel ? hbw_pkg::HBW_HAVE_HI
						: hbw_pkg::HBW_HAVE_LO;
				end
				hbw_pkg::HBW_HAVE_LO, hbw_pkg::HBW_HAVE_HI:
				begin
					nxt_s.d_out = low_lines(pick_half(hsel, s_ff.rdata));
					if (same_half(hsel, s_ff.rpair))
						nxt_s.rd_drop = 1'b1;
					else
						nxt_s.ireq.rd_adv = 1'b1;
					nxt_s.rpair = hbw_pkg::HBW_IDLE;
				end
				default:
					nxt_s.rpair = hbw_pkg::HBW_IDLE;
			endcase
			nxt_s.d_oe_lo = 1'b1;
			nxt_s.d_oe_hi = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			s_ff <= '0;
			s_ff.wpair <= hbw_pkg::HBW_IDLE;
			s_ff.rpair <= hbw_pkg::HBW_IDLE;
		end
		else
			s_ff <= nxt_s;
	end

	assign d_out = s_ff.d_out;
	assign d_oe = {{`HBW_HALF_W{s_ff.d_oe_hi}}, {`HBW_HALF_W{s_ff.d_oe_lo}}};
	assign hardware_configuration = s_ff.cfg;
	assign int_req = s_ff.ireq;
	assign rd_pair_reset = s_ff.rd_drop;
	assign wr_discard = s_ff.wr_drop;

	// Each check on an access looks one edge after it, where the answer stands.
	// A dropped pair leaves no trace on the internal side, so the pulses
	// and the pair state are watched together.

	a_upper_undriven: assert property (
		@(posedge mclk) disable iff (!resetn)
		s_ff.bus16 |-> d_oe[`HBW_HI_MSB:`HBW_HI_LSB] == 16'h0000)
		else $error("upper data lines driven in 16-bit width");

	a_width_report: assert property (
		@(posedge mclk) disable iff (!resetn)
		s_ff.strap_taken
		|-> hardware_configuration[`HBW_CFG_WIDTH_BIT] == ~s_ff.bus16)
		else $error("width bit does not match strap");

	a_cfg_hold: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && $past(s_ff.strap_taken))
		|-> $stable(hardware_configuration))
		else $error("width report changed without reset");

	a_discard_nowr: assert property (
		@(posedge mclk) disable iff (!resetn)
		wr_discard |-> !int_req.wr)
		else $error("discarded pair still wrote");

	a_wr_drop_clear: assert property (
		@(posedge mclk) disable iff (!resetn)
		wr_discard |-> s_ff.wpair == hbw_pkg::HBW_IDLE)
		else $error("write pairing not cleared after discard");

	a_pair_commit: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.bus16 && int_req.wr)
		|-> $past(s_ff.wpair) != hbw_pkg::HBW_IDLE)
		else $error("16-bit write committed after one half");

	a_wr_spacing: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.bus16 && int_req.wr) |=> !int_req.wr)
		else $error("16-bit writes committed on adjacent cycles");

	a_wr_first_hold: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.wr
		&& s_ff.wpair == hbw_pkg::HBW_IDLE) |=> !int_req.wr
		&& s_ff.whold == $past(host_req.wdata[`HBW_LO_MSB:0]))
		else $error("first write half not held back");

	a_wr_first_addr: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.wr
		&& s_ff.wpair == hbw_pkg::HBW_IDLE)
		|=> int_req.dw_addr == $past(host_req.dw_addr))
		else $error("pair address not taken from first half");

	a_rd_restart: assert property (
		@(posedge mclk) disable iff (!resetn)
		rd_pair_reset |-> s_ff.rpair == hbw_pkg::HBW_IDLE)
		else $error("read pairing not cleared");

	a_rd_drop_noadv: assert property (
		@(posedge mclk) disable iff (!resetn)
		rd_pair_reset |-> !int_req.rd_adv)
		else $error("repeated half read still advanced");

	a_rd_first_snap: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.rd
		&& !host_req.wr && s_ff.rpair == hbw_pkg::HBW_IDLE)
		|=> !int_req.rd_adv && s_ff.rdata == $past(int_rdata))
		else $error("first read half advanced or lost the word");

	a_rd_second_adv: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.rd
		&& !host_req.wr && s_ff.rpair != hbw_pkg::HBW_IDLE
		&& !same_half(hsel, s_ff.rpair)) |=> int_req.rd_adv)
		else $error("completed read pair did not advance");

	a_rd_spacing: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.bus16 && int_req.rd_adv) |=> !int_req.rd_adv)
		else $error("16-bit reads advanced on adjacent cycles");

	a_rd_oe_low: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.rd
		&& !host_req.wr) |=> d_oe == `HBW_OE_LOW_ONLY)
		else $error("16-bit read enables wrong lines");

	a_rd16_upper_zero: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.rd
		&& !host_req.wr) |=> d_out[`HBW_HI_MSB:`HBW_HI_LSB] == 16'h0000)
		else $error("16-bit read data has upper bits set");

	a_native_single: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && !s_ff.bus16 && host_req.cs && host_req.wr)
		|=> int_req.wr && int_req.wdata == $past(host_req.wdata))
		else $error("32-bit write not passed through whole");

	a_native_read: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && !s_ff.bus16 && host_req.cs && host_req.rd)
		|=> d_oe == `HBW_OE_ALL && d_out == $past(int_rdata))
		else $error("32-bit read not returned whole");

	a_native_no_pair: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && !s_ff.bus16) |-> !wr_discard && !rd_pair_reset)
		else $error("pairing error flagged in 32-bit width");

	a_swap_lo_first: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.wr
		&& s_ff.wpair == hbw_pkg::HBW_HAVE_LO
		&& word_swap == `HBW_SWAP_NONE && host_req.a1)
		|=> int_req.wdata[`HBW_LO_MSB:0] == $past(s_ff.whold))
		else $error("A1 low half not placed in low word");

	a_swap_other: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.wr
		&& s_ff.wpair == hbw_pkg::HBW_HAVE_HI
		&& word_swap != `HBW_SWAP_ALL_ONES && !host_req.a1) |=> int_req.wr
		&& int_req.wdata[`HBW_LO_MSB:0] == $past(host_req.wdata[`HBW_LO_MSB:0]))
		else $error("default mapping put A1 low in high word");

	a_swap_mode: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.wr
		&& s_ff.wpair == hbw_pkg::HBW_IDLE && word_swap == `HBW_SWAP_ALL_ONES
		&& !host_req.a1) |=> s_ff.wpair == hbw_pkg::HBW_HAVE_HI)
		else $error("swapped A1 low not taken as high word");

	a_swap_hi_first: assert property (
		@(posedge mclk) disable iff (!resetn)
		(s_ff.strap_taken && s_ff.bus16 && host_req.cs && host_req.wr
		&& s_ff.wpair == hbw_pkg::HBW_HAVE_LO
		&& word_swap == `HBW_SWAP_ALL_ONES && !host_req.a1) |=> int_req.wr
		&& int_req.wdata[`HBW_HI_MSB:`HBW_HI_LSB] == $past(host_req.wdata[`HBW_LO_MSB:0]))
		else $error("swapped mapping put A1 low in low word");
endmodule

//--- hbw_host_model.sv
// Host processor model that issues one-cycle host port accesses.
`timescale 1ns/1ns
module hbw_host_model
(
	input wire logic mclk,
	output hbw_pkg::hbw_host_req_t req
);
	initial req = '0;
	// Callers pass one dw for both halves of a pair.
	task automatic acc(input logic w, input logic a1,
		input logic [29:0] dw, input logic [31:0] d);
	begin
		@(posedge mclk);
		#1 req = '{1'h1, w, !w, a1, dw, d};
	end
	endtask
	// Released lines show the inverse, so stale values never match.
	task automatic idle();
	begin
		@(posedge mclk);
		#1 req = '{1'h0, 1'h0, 1'h0, !req.a1, ~req.dw_addr, ~req.wdata};
	end
	endtask
endmodule

//--- test_hbw_host_port.sv
// Self-checking bench for the host port width adapter.
`timescale 1ns/1ns
module test_hbw_host_port;
	logic mclk, resetn, strap, rpr, wdis;
	logic [31:0] swap, rdat, d_out, d_oe, cfg;
	hbw_pkg::hbw_host_req_t req;
	hbw_pkg::hbw_int_req_t ireq;
	int n_errors, cmp_count;
	hbw_host_port i_hbw_host_port(.mclk(mclk), .resetn(resetn),
		.serial_memory_data_strap_pin(strap), .word_swap(swap),
		.host_req(req), .int_rdata(rdat), .d_out(d_out), .d_oe(d_oe),
		.hardware_configuration(cfg), .int_req(ireq),
		.rd_pair_reset(rpr), .wr_discard(wdis));
	hbw_host_model i_hbw_host_model(.mclk(mclk), .req(req));
	initial
	begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
	begin
		cmp_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task automatic summarize();
	begin
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	task automatic rst(input logic s);
	begin
		@(posedge mclk);
		#1 resetn = 1'h0;
		strap = s;
		repeat (20) @(posedge mclk);
		#1 resetn = 1'h1;
	end
	endtask
	task automatic t_wr16();
	begin
		i_hbw_host_model.acc(1'h1, 1'h0, 30'h5, 32'h1111aaaa);
		i_hbw_host_model.acc(1'h1, 1'h1, 30'h5, 32'h2222bbbb);
		chk(ireq.wr, 1'h0);
		i_hbw_host_model.idle();
		chk({ireq.wr, ireq.dw_addr, ireq.wdata},
			{1'h1, 30'h5, 32'hbbbbaaaa});
		swap = 32'hffffffff;
		i_hbw_host_model.acc(1'h1, 1'h1, 30'h6, 32'h0000cccc);
		i_hbw_host_model.acc(1'h1, 1'h0, 30'h6, 32'h0000dddd);
		i_hbw_host_model.idle();
		chk({ireq.wr, ireq.wdata}, {1'h1, 32'hddddcccc});
		i_hbw_host_model.acc(1'h1, 1'h0, 30'h7, 32'h00001234);
		i_hbw_host_model.acc(1'h1, 1'h0, 30'h7, 32'h00005678);
		i_hbw_host_model.idle();
		chk({wdis, ireq.wr}, 2'h2);
		chk(cfg, 32'h0);
		swap = 32'h0000ffff;
		i_hbw_host_model.acc(1'h1, 1'h1, 30'h8, 32'h0000eeee);
		i_hbw_host_model.acc(1'h1, 1'h0, 30'h8, 32'h0000ffff);
		i_hbw_host_model.idle();
		chk({ireq.wr, ireq.wdata}, {1'h1, 32'heeeeffff});
		$display("write16 test done");
	end
	endtask
	task automatic t_rd16();
	begin
		swap = 32'h0;
		rdat = 32'h87654321;
		i_hbw_host_model.acc(1'h0, 1'h1, 30'h9, 32'h0);
		i_hbw_host_model.acc(1'h0, 1'h0, 30'h9, 32'h0);
		chk({d_oe, d_out}, {32'h0000ffff, 32'h00008765});
		rdat = 32'h0;
		i_hbw_host_model.idle();
		chk({ireq.rd_adv, d_out}, {1'h1, 32'h00004321});
		rdat = 32'h87654321;
		i_hbw_host_model.acc(1'h0, 1'h0, 30'h9, 32'h0);
		i_hbw_host_model.acc(1'h0, 1'h0, 30'h9, 32'h0);
		i_hbw_host_model.idle();
		chk({rpr, ireq.rd_adv}, 2'h2);
		i_hbw_host_model.acc(1'h0, 1'h0, 30'h9, 32'h0);
		i_hbw_host_model.acc(1'h0, 1'h1, 30'h9, 32'h0);
		i_hbw_host_model.idle();
		chk({ireq.rd_adv, d_out}, {1'h1, 32'h00008765});
		swap = 32'hffffffff;
		rdat = 32'h13572468;
		i_hbw_host_model.acc(1'h0, 1'h1, 30'ha, 32'h0);
		i_hbw_host_model.acc(1'h0, 1'h0, 30'ha, 32'h0);
		chk(d_out, 32'h00002468);
		i_hbw_host_model.idle();
		chk({ireq.rd_adv, d_out}, {1'h1, 32'h00001357});
		$display("read16 test done");
	end
	endtask
	task automatic t_32();
	begin
		swap = 32'hffffffff;
		i_hbw_host_model.acc(1'h1, 1'h0, 30'h3, 32'h12345678);
		i_hbw_host_model.acc(1'h1, 1'h0, 30'h3, 32'h9abcdef0);
		chk({ireq.wr, ireq.wdata}, {1'h1, 32'h12345678});
		i_hbw_host_model.idle();
		chk({wdis, ireq.wr, ireq.wdata}, {2'h1, 32'h9abcdef0});
		rdat = 32'hcafe1234;
		i_hbw_host_model.acc(1'h0, 1'h1, 30'h4, 32'h0);
		i_hbw_host_model.idle();
		chk({d_oe, d_out}, {32'hffffffff, 32'hcafe1234});
		chk(cfg, 32'h4);
		$display("bus32 test done");
	end
	endtask
	initial
	begin
		resetn = 1'h0;
		strap = 1'h0;
		swap = 32'h0;
		rdat = 32'h0;
		rst(1'h0);
		t_wr16();
		t_rd16();
		rst(1'h1);
		t_32();
		summarize();
	end
	initial
	begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		summarize();
	end
endmodule
